/* hdl/eep_pkg.sv */
package eep_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 50;            // Reference clock period
  localparam int WRITE_CYCLE_MS  = 6;             // Longest program cycle
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int GLITCH_STD_NS   = 100;           // Suppression, 100 kHz mode
  localparam int GLITCH_FAST_NS  = 50;            // Suppression, 400 kHz mode
  localparam int GLITCH_STD_CYC  = (GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_FAST_CYC = (GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_DIV        = 100;           // Host clock half period in cycles
  // ****************************************************************
  // Address fields
  // ****************************************************************
  localparam logic [3:0] MEM_TYPE_CODE = 4'h6;    // Memory class type code, value arbitrary
  localparam int TYPE_MSB   = 7;                  // Device type field top bit
  localparam int SEL_MSB    = 3;                  // Select field top bit
  localparam int RW_POS     = 0;                  // Direction bit position
  localparam int HI_BITS    = 6;                  // Decoded bits of upper byte
  localparam int ARRAY_AW   = 14;                 // Array address width
  // ****************************************************************
  // Host command register offsets
  // ****************************************************************
  localparam logic [3:0] REG_CMD    = 4'h0;       // Go, direction
  localparam logic [3:0] REG_ADDR   = 4'h1;       // Select and array address
  localparam logic [3:0] REG_WDATA  = 4'h2;       // Byte to write
  localparam logic [3:0] REG_STATUS = 4'h3;       // Busy, nack, read data
  localparam logic [31:0] CMD_RESET = 32'h0;      // Command after reset
endpackage : eep_pkg

/* hdl/eep_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-wire bus joining master and memory; pins are open drain
interface eep_bus_if;
  logic sclOut;    // Master clock drive level
  logic sclOe;     // Master clock pull enable
  logic sdaMOut;   // Master data level
  logic sdaMOe;    // Master pulls data low
  logic sdaSOut;   // Memory data level
  logic sdaSOe;    // Memory pulls data low
  logic scl;       // Resolved clock wire
  logic sda;       // Resolved data wire
  // Wired-and with pull-up
  assign scl = !(sclOe && !sclOut);
  assign sda = !(sdaMOe && !sdaMOut) && !(sdaSOe && !sdaSOut);
  modport master (output sclOut, sclOe, sdaMOut, sdaMOe, input scl, sda);
  modport slave  (output sdaSOut, sdaSOe, input scl, sda);
endinterface : eep_bus_if
`default_nettype wire

/* hdl/eep_pin_filter.sv */
`timescale 1ns/10ps
`default_nettype none
// Three-stage sampler plus width filter for one pin
module eep_pin_filter #(
  parameter int HOLD = 2                // Cycles a level must last
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      level
);
  logic [2:0] syncChain;                // First stage read only by second
  logic [7:0] stable;                   // Agreement counter
  // Sampler chain
  always_ff @(posedge ref_clk)
    if (!reset_n)
      syncChain <= 3'h7;
    else
      syncChain <= {syncChain[1:0], pinIn};
  // Change accepted once stages two and three agree long enough
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      stable <= 8'h0;
      level  <= 1'b1;
    end
    else if (syncChain[1] != syncChain[2] || syncChain[2] == level)
      stable <= 8'h0;
    else if (stable >= 8'(HOLD - 1))
    begin
      level  <= syncChain[2];
      stable <= 8'h0;
    end
    else
      stable <= stable + 8'h1;
endmodule : eep_pin_filter
`default_nettype wire

/* hdl/eep_mem_slave.sv */
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Memory end of the two-wire bus
// ****************************************************************
// Notes on behaviour
// - Program cycle after write stop, within 6ms
// - Busy: release data, ignore own address
// - Two array address bytes follow address
// - Address byte: type, select, direction
// - Respond only on matching type code
// - Select field must equal strap pins
// - Select field picks 64K page block; here it is only compared with the straps
// - Last bit one reads, zero writes
// - Receiver pulls data low ninth clock
// - Transmitter releases line, awaits acknowledge
// - First byte high, second byte low
// - Master starts, sends bytes, stops
// - Fields sent in fixed order
// - Protect high blocks program, reads work
// - Protected: address acked, data not
// - Protect input defaults unprotected
// - Data line only pulled low
// - Shift only on master clock
// - Ignore pulses under suppression window
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Upper byte uses six low bits
module eep_mem_slave
  import eep_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC,  // Program cycle length
  parameter int PAGE_BYTES   = 64,               // Page buffer depth
  parameter int GLITCH_CYC   = GLITCH_FAST_CYC   // Filter width
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  eep_bus_if.slave        bus,
  input  wire logic [2:0] chip_select_straps,    // Strap levels
  input  wire logic       writeProtect,          // High blocks programming
  output logic            programBusy            // Program cycle running
);
  typedef enum {EEP_IDLE, EEP_DEVADDR, EEP_ADDRHI, EEP_ADDRLO, EEP_WDATA,
                EEP_RDATA, EEP_ACK, EEP_MACK, EEP_IGNORE} eep_state_t;
  localparam int PW = $clog2(PAGE_BYTES);
  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [7:0]          memArray [0:(1<<ARRAY_AW)-1]; // Whole array
  logic [7:0]          pageBuf  [0:PAGE_BYTES-1];    // Pending page data
  logic [PAGE_BYTES-1:0] pageValid;                  // Which bytes pending
  logic [ARRAY_AW-1:0] addrPtr;                      // Internal address
  logic [ARRAY_AW-1:0] pageBase;                     // Page of pending write
  eep_state_t          state;                        // Protocol state
  eep_state_t          afterAck;                     // State after ack bit
  logic [7:0]          shiftReg;                     // Byte being moved
  logic [3:0]          bitCnt;                       // Bits done in byte
  logic                isRead;                       // Direction latched
  logic                ackDrive;                     // We pull data low
  logic                dataDrive;                    // Read bit value
  logic                writeArmed;                   // Acked data pending
  logic [31:0]         progCnt;                      // Program countdown
  logic                sclF, sdaF, sclQ, sdaQ;       // Filtered and delayed
  logic                startSeen, stopSeen;          // Bus conditions
  logic                sclRise, sclFall;             // Clock edges
  logic                wpSync;                       // Protect, synchronised
  logic [2:0]          wpPipe;                       // Protect sampler
  logic [ARRAY_AW-1:0] nextAddr;                     // Address after byte
  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  // glitch filter
  eep_pin_filter #(.HOLD(GLITCH_CYC)) u_sclFilt (.ref_clk(ref_clk), .reset_n(reset_n),
    .pinIn(bus.scl), .level(sclF));
  eep_pin_filter #(.HOLD(GLITCH_CYC)) u_sdaFilt (.ref_clk(ref_clk), .reset_n(reset_n),
    .pinIn(bus.sda), .level(sdaF));
  always_ff @(posedge ref_clk)
    if (!reset_n)
      wpPipe <= 3'h0;
    else
      wpPipe <= {wpPipe[1:0], writeProtect};
  always_ff @(posedge ref_clk)
    if (!reset_n)
      wpSync <= 1'b0;
    else if (wpPipe[1] == wpPipe[2])
      wpSync <= wpPipe[2];
  // Delayed copies for edge detection
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end
    else
    begin
      sclQ <= sclF;
      sdaQ <= sdaF;
    end
  assign sclRise   = sclF && !sclQ;
  assign sclFall   = !sclF && sclQ;
  assign startSeen = sclF && sclQ && sdaQ && !sdaF;
  assign stopSeen  = sclF && sclQ && !sdaQ && sdaF;
  // Plain increment, shared by read and write; write keeps only the page bits
  function automatic logic [ARRAY_AW-1:0] bump(input logic [ARRAY_AW-1:0] a);
    bump = a + ARRAY_AW'(1);
  endfunction : bump
  assign nextAddr = bump(addrPtr);
  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      state      <= EEP_IDLE;
      afterAck   <= EEP_IDLE;
      shiftReg   <= 8'h0;
      bitCnt     <= 4'h0;
      isRead     <= 1'b0;
      ackDrive   <= 1'b0;
      dataDrive  <= 1'b1;
      writeArmed <= 1'b0;
      addrPtr    <= '0;
      pageBase   <= '0;
      pageValid  <= '0;
    end
    else if (programBusy)
    begin
      state     <= EEP_IDLE;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b1;
    end
    else if (startSeen)
    begin
      // Repeated start keeps pointer and pending data
      state     <= EEP_DEVADDR;
      bitCnt    <= 4'h0;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b1;
    end
    else if (stopSeen)
    begin
      state     <= EEP_IDLE;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b1;
      writeArmed <= 1'b0;
    end
    else
      case (state)
        EEP_DEVADDR, EEP_ADDRHI, EEP_ADDRLO, EEP_WDATA:
          if (sclRise)
          begin
            shiftReg <= {shiftReg[6:0], sdaF};
            bitCnt   <= bitCnt + 4'h1;
          end
          else if (sclFall && bitCnt == 4'h8)
          begin
            bitCnt <= 4'h0;
            state  <= EEP_ACK;
            if (state == EEP_DEVADDR)
            begin
              if (shiftReg[TYPE_MSB -: 4] == MEM_TYPE_CODE &&
                  shiftReg[SEL_MSB -: 3] == chip_select_straps)
              begin
                ackDrive <= 1'b1;
                isRead   <= shiftReg[RW_POS];
                // address bytes follow a write address
                afterAck <= shiftReg[RW_POS] ? EEP_RDATA : EEP_ADDRHI;
                if (shiftReg[RW_POS])
                  shiftReg <= memArray[addrPtr];
              end
              else
                state <= EEP_IGNORE;
            end
            else if (state == EEP_ADDRHI)
            begin
              addrPtr[ARRAY_AW-1:8] <= shiftReg[HI_BITS-1:0];
              ackDrive <= 1'b1;
              afterAck <= EEP_ADDRLO;
            end
            else if (state == EEP_ADDRLO)
            begin
              addrPtr[7:0] <= shiftReg;
              pageBase     <= {addrPtr[ARRAY_AW-1:8], shiftReg};
              pageValid    <= '0;
              ackDrive     <= 1'b1;
              afterAck     <= EEP_WDATA;
            end
            else if (!wpSync)
            begin
              pageBuf[addrPtr[PW-1:0]]   <= shiftReg;
              pageValid[addrPtr[PW-1:0]] <= 1'b1;
              addrPtr[PW-1:0] <= nextAddr[PW-1:0];
              writeArmed <= 1'b1;
              ackDrive   <= 1'b1;
              afterAck   <= EEP_WDATA;
            end
            else
              state <= EEP_IGNORE;
          end
        EEP_ACK:
          if (sclFall)
          begin
            ackDrive <= 1'b0;
            state    <= afterAck;
            if (afterAck == EEP_RDATA)
            begin
              dataDrive <= shiftReg[7];
              shiftReg  <= {shiftReg[6:0], 1'b1};
              bitCnt    <= 4'h1;
            end
          end
        EEP_RDATA:
          if (sclFall)
          begin
            if (bitCnt == 4'h8)
            begin
              // release and wait for master ack
              dataDrive <= 1'b1;
              addrPtr   <= nextAddr;
              state     <= EEP_MACK;
            end
            else
            begin
              dataDrive <= shiftReg[7];
              shiftReg  <= {shiftReg[6:0], 1'b1};
              bitCnt    <= bitCnt + 4'h1;
            end
          end
        EEP_MACK:
          if (sclRise)
            // Master ack continues, nack ends the read
            state <= sdaF ? EEP_IGNORE : EEP_ACK;
          else if (state == EEP_MACK)
          begin
            shiftReg <= memArray[addrPtr];
            afterAck <= EEP_RDATA;
          end
        default:
          state <= state;
      endcase
  // ****************************************************************
  // Program cycle
  // ****************************************************************
  // timed program after armed stop
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      programBusy <= 1'b0;
      progCnt     <= 32'h0;
    end
    else if (!programBusy && stopSeen && writeArmed && !wpSync)
    begin
      programBusy <= 1'b1;
      progCnt     <= 32'(WRITE_CYCLES - 1);
    end
    else if (programBusy)
    begin
      if (progCnt == 32'h0)
        programBusy <= 1'b0;
      else
        progCnt <= progCnt - 32'h1;
    end
  // Commit pending page at end of program cycle
  always_ff @(posedge ref_clk)
    if (programBusy && progCnt == 32'h0)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (pageValid[i])
          memArray[{pageBase[ARRAY_AW-1:PW], PW'(i)}] <= pageBuf[i];
  // open drain: enable only when pulling low
  assign bus.sdaSOut = 1'b0;
  assign bus.sdaSOe  = ackDrive || !dataDrive;
endmodule : eep_mem_slave
`default_nettype wire

/* hdl/eep_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Master end: one byte read or write per command
// ****************************************************************
module eep_bus_master
  import eep_pkg::*;
#(
  parameter int HALF = HOST_DIV          // Clock half period in cycles
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  eep_bus_if.master        bus,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata
);
  typedef enum {EBM_IDLE, EBM_START, EBM_BYTE, EBM_ACK, EBM_STOP} ebm_state_t;
  ebm_state_t  state;                    // Sequencer
  logic [18:0] addrReg;                  // Select(18:16), array address
  logic [7:0]  wdata, rdata, shiftOut;   // Data registers
  logic        dirRead, nackSeen;        // Command direction, failure
  logic [2:0]  byteIdx;                  // Byte of the command string
  logic [3:0]  bitCnt;                   // Bit within byte
  logic [15:0] divCnt;                   // Clock divider
  logic [1:0]  phase;                    // Quarter of a bit period
  logic        sclDrv, sdaDrv, tick;     // Pin levels, quarter tick
  logic        goPulse;                  // Command launch
  logic [2:0]  sdaPipe;                  // Data line sampler
  logic        sdaIn;                    // Agreed data line level
  assign goPulse = regWrite && regAddr == REG_CMD && regWdata[0] && state == EBM_IDLE;
  assign tick    = divCnt == 16'(HALF / 2 - 1);
  // Host registers
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      addrReg <= '0;
      wdata   <= 8'h0;
      dirRead <= 1'b0;
    end
    else if (regWrite && regAddr == REG_ADDR)
      addrReg <= regWdata[18:0];
    else if (regWrite && regAddr == REG_WDATA)
      wdata <= regWdata[7:0];
    else if (goPulse)
      dirRead <= regWdata[1];
  // Read port, data one cycle later
  always_ff @(posedge ref_clk)
    if (!reset_n)
      regRdata <= 32'h0;
    else if (regRead && regAddr == REG_STATUS)
      regRdata <= {22'h0, nackSeen, state != EBM_IDLE, rdata};
    else if (regRead && regAddr == REG_ADDR)
      regRdata <= {13'h0, addrReg};
    else
      regRdata <= 32'h0;
  // Data line sampled through three stages
  always_ff @(posedge ref_clk)
    if (!reset_n)
      sdaPipe <= 3'h7;
    else
      sdaPipe <= {sdaPipe[1:0], bus.sda};
  // Level taken only once stages two and three agree
  always_ff @(posedge ref_clk)
    if (!reset_n)
      sdaIn <= 1'b1;
    else if (sdaPipe[1] == sdaPipe[2])
      sdaIn <= sdaPipe[2];
  // Quarter period divider
  always_ff @(posedge ref_clk)
    if (!reset_n || state == EBM_IDLE || tick)
      divCnt <= 16'h0;
    else
      divCnt <= divCnt + 16'h1;
  // Command string: start, address, hi, lo, data or restart read
  always_ff @(posedge ref_clk)
    if (!reset_n)
    begin
      state    <= EBM_IDLE;
      phase    <= 2'h0;
      sclDrv   <= 1'b1;
      sdaDrv   <= 1'b1;
      byteIdx  <= 3'h0;
      bitCnt   <= 4'h0;
      shiftOut <= 8'h0;
      rdata    <= 8'h0;
      nackSeen <= 1'b0;
    end
    else if (goPulse)
    begin
      state    <= EBM_START;
      phase    <= 2'h0;
      byteIdx  <= 3'h0;
      nackSeen <= 1'b0;
    end
    else if (tick)
    begin
      phase <= phase + 2'h1;
      case (state)
        EBM_START:
          case (phase)
            2'h0:
            begin
              sdaDrv <= 1'b1;
              sclDrv <= 1'b1;
            end
            2'h1: sdaDrv <= 1'b0;
            2'h2: sclDrv <= 1'b0;
            default:
            begin
              state  <= EBM_BYTE;
              bitCnt <= 4'h0;
              shiftOut <= {MEM_TYPE_CODE, addrReg[18:16], byteIdx == 3'h4};
            end
          endcase
        EBM_BYTE:
          case (phase)
            2'h0: sdaDrv <= (byteIdx == 3'h5) ? 1'b1 : shiftOut[7];
            2'h1: sclDrv <= 1'b1;
            2'h2: rdata  <= {rdata[6:0], sdaIn};
            default:
            begin
              sclDrv   <= 1'b0;
              shiftOut <= {shiftOut[6:0], 1'b0};
              bitCnt   <= bitCnt + 4'h1;
              if (bitCnt == 4'h7)
                state <= EBM_ACK;
            end
          endcase
        EBM_ACK:
          case (phase)
            // release line; on read data this is the nack
            2'h0: sdaDrv <= 1'b1;
            2'h1: sclDrv <= 1'b1;
            2'h2: if (byteIdx != 3'h5 && sdaIn) nackSeen <= 1'b1;
            default:
            begin
              sclDrv <= 1'b0;
              bitCnt <= 4'h0;
              byteIdx <= byteIdx + 3'h1;
              if ((byteIdx != 3'h5 && nackSeen) || byteIdx == 3'h5 ||
                  (byteIdx == 3'h3 && !dirRead))
                state <= EBM_STOP;
              else if (byteIdx == 3'h2 && dirRead)
              begin
                state <= EBM_START;
                byteIdx <= 3'h4;
              end
              else
              begin
                state <= EBM_BYTE;
                shiftOut <= byteIdx == 3'h0 ? {2'h0, addrReg[13:8]} :
                            byteIdx == 3'h1 ? addrReg[7:0] : wdata;
                if (byteIdx == 3'h4) byteIdx <= 3'h5;
              end
            end
          endcase
        EBM_STOP:
          case (phase)
            2'h0: sdaDrv <= 1'b0;
            2'h1: sclDrv <= 1'b1;
            2'h2: sdaDrv <= 1'b1;
            default: state <= EBM_IDLE;
          endcase
        default: phase <= 2'h0;
      endcase
    end
  // Open-drain drive of both lines
  assign bus.sclOut  = 1'b0;
  assign bus.sclOe   = !sclDrv;
  assign bus.sdaMOut = 1'b0;
  assign bus.sdaMOe  = !sdaDrv;
endmodule : eep_bus_master
`default_nettype wire

/* tb/eep_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Link watcher beside the joining interface
// ****************************************************************
module eep_props #(
  parameter int WRITE_CYCLES = 2000  // Program cycle length
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sdaSOut,
  input wire logic sdaSOe,
  input wire logic scl,
  input wire logic sda,
  input wire logic programBusy
);
  logic [31:0] busyCnt;  // Cycles spent programming
  logic [7:0]  stopAge;  // Cycles since stop, saturates
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Length of the current program cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !programBusy) busyCnt <= 32'h0;
    else busyCnt <= busyCnt + 32'h1;
  end
  // Age of the last stop; saturating avoids wrap to a false recent stop
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n) stopAge <= 8'hff;
    else if (scl && $past(scl) && sda && !$past(sda)) stopAge <= 8'h0;
    else if (stopAge != 8'hff) stopAge <= stopAge + 8'h1;
  end
  sequence s_pull; !scl && $rose(sdaSOe); endsequence
  sequence s_low4; !scl [*4]; endsequence
  property p_sda_od; sdaSOe |-> !sdaSOut; endproperty
  a_sda_od: assert property (p_sda_od) else $error("memory drove data high");
  property p_sda_hold; scl && $past(scl) |-> $stable(sdaSOe); endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high");
  property p_ack_hold; s_pull |-> ##1 s_low4; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull not inside clock low");
  property p_ack_release; $fell(sdaSOe) |-> !scl; endproperty
  a_ack_release: assert property (p_ack_release) else $error("release with clock high");
  property p_busy_quiet; programBusy |-> !sdaSOe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer while programming");
  property p_busy_bound; programBusy |-> busyCnt <= WRITE_CYCLES; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("program cycle too long");
  property p_busy_min; $rose(programBusy) |-> programBusy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("program cycle cut short");
  property p_busy_stop; $rose(programBusy) |-> stopAge < 8'h20; endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("program without stop");
endmodule : eep_props
`default_nettype wire

/* tb/eeprom_two_byte_addr_i2c_slave_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Bench: register port drives master, memory answers
// ****************************************************************
module eeprom_two_byte_addr_i2c_slave_tb
  import eep_pkg::*;
;
  localparam int         WC    = 2000;  // Short program cycle
  localparam logic [2:0] STRAP = 3'h5;  // Memory strap levels
  logic        ref_clk      = 1'b0;
  logic        reset_n      = 1'b0;
  logic        writeProtect = 1'b0;
  logic        programBusy;
  logic [3:0]  regAddr      = 4'h0;
  logic [31:0] regWdata     = 32'h0;
  logic        regWrite     = 1'b0;
  logic        regRead      = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] lfsr         = 32'h5a1ad1a4;  // Random source
  logic [13:0] wrAddr [0:7];                // Addresses written
  logic [7:0]  wrData [0:7];                // Data written there
  int          miscompares  = 0;
  int          compares     = 0;
  eep_bus_if bus ();
  eep_mem_slave #(.WRITE_CYCLES(WC), .PAGE_BYTES(64), .GLITCH_CYC(GLITCH_FAST_CYC)) i_eep_mem_slave (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .chip_select_straps(STRAP),
    .writeProtect(writeProtect), .programBusy(programBusy));
  eep_bus_master #(.HALF(20)) i_eep_bus_master (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  eep_props #(.WRITE_CYCLES(WC)) i_eep_props (.ref_clk(ref_clk), .reset_n(reset_n), .sdaSOut(bus.sdaSOut),
    .sdaSOe(bus.sdaSOe), .scl(bus.scl), .sda(bus.sda), .programBusy(programBusy));
  // Clock and reset
  initial
  begin
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    next_rand = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : next_rand
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : reg_wr
  // Data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : reg_rd
  // One command on the link, then poll until done
  task automatic run(input logic [2:0] s, input logic [13:0] a, input logic [7:0] d, input logic r,
                     output logic [31:0] st);
    reg_wr(REG_ADDR, {13'h0, s, 2'h0, a});
    reg_wr(REG_WDATA, {24'h0, d});
    reg_wr(REG_CMD, {30'h0, r, 1'b1});
    st = 32'h100;
    for (int n = 0; n < 9000 && st[8] !== 1'b0; n++) reg_rd(REG_STATUS, st);
    check(32'(st[8]), 32'h0);
  endtask : run
  task automatic wait_busy(input logic v, input int lim);
    for (int n = 0; n < lim && programBusy !== v; n++) @(posedge ref_clk);
    if (!v) check(32'(programBusy), 32'h0);
  endtask : wait_busy
  // Latest byte written to the address of entry k
  function automatic logic [7:0] expect_at(input int k);
    expect_at = wrData[k];
    for (int j = k + 1; j < 8; j++)
      if (wrAddr[j] == wrAddr[k]) expect_at = wrData[j];
  endfunction : expect_at
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Watchdog against a hung link
  initial
  begin
    #4500000;
    miscompares++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    logic [31:0] st;
    logic [13:0] a;
    repeat (6) @(posedge ref_clk);
    check(32'({programBusy, bus.sda}), 32'h1);
    reg_wr(4'hf, lfsr);
    for (int i = 0; i < 8; i++)
    begin
      lfsr = next_rand(lfsr);
      a = (i == 0) ? 14'h3fff : (i == 1) ? 14'h0 : lfsr[13:0];
      wait_busy(1'b0, WC + 100);
      run(STRAP, a, lfsr[21:14], 1'b0, st);
      check(32'(st[9]), 32'h0);
      wrAddr[i] = a;
      wrData[i] = lfsr[21:14];
      wait_busy(1'b1, 40);
      check(32'(programBusy), 32'h1);
      if (i == 0) run(STRAP, a, 8'h0, 1'b1, st);
      if (i == 0) check(32'(st[9]), 32'h1);
    end
    wait_busy(1'b0, WC + 100);
    @(posedge ref_clk);
    writeProtect <= 1'b1;
    run(STRAP, a, ~expect_at(7), 1'b0, st);
    check(32'(st[9]), 32'h1);
    wait_busy(1'b1, 40);
    check(32'(programBusy), 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      run(3'(s), a, 8'h0, 1'b1, st);
      check(32'(st[9]), 32'(3'(s) != STRAP));
    end
    writeProtect <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      run(STRAP, wrAddr[k], 8'h0, 1'b1, st);
      check({22'h0, st[9:0]}, {24'h0, expect_at(k)});
    end
    report_and_stop();
  end
endmodule : eeprom_two_byte_addr_i2c_slave_tb
`default_nettype wire
